// [verilog/usart_rx_pkg.sv]
// Constants, register map and field layout of the synchronous slave
// receiver. Assumes an APB master on pclk and an external shift clock.
package usart_rx_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL   = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS    = 8'h0C;
  localparam logic [7:0] IDX_RECEIVE_STATUS      = 8'h18;
  localparam logic [7:0] IDX_RECEIVE_BUFFER      = 8'h1A;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES  = 8'h8C;
  localparam logic [7:0] IDX_TRANSMIT_STATUS     = 8'h98;
  localparam logic [7:0] IDX_BAUD_RATE_DIVISOR   = 8'h99;
  localparam logic [1:0] ADDR_PAD = 2'h0;
  localparam int GLOBAL_ENABLE_BIT      = 7;
  localparam int PERIPHERAL_ENABLE_BIT  = 6;
  localparam int RECEIVE_COMPLETE_BIT   = 5;
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int NINE_BIT_SELECT_BIT    = 6;
  localparam int SINGLE_RECEIVE_BIT     = 5;
  localparam int CONTINUOUS_RECEIVE_BIT = 4;
  localparam int ADDRESS_DETECT_BIT     = 3;
  localparam int FRAMING_ERROR_BIT      = 2;
  localparam int OVERRUN_ERROR_BIT      = 1;
  localparam int NINTH_BIT_POS          = 0;
  localparam int CLOCK_SOURCE_BIT       = 7;
  localparam int SYNC_MODE_BIT          = 4;
  localparam int SHIFT_EMPTY_BIT        = 1;
  localparam logic [7:0] RESET_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RESET_PERIPHERAL_ENABLES = 8'h00;
  localparam logic [7:0] RESET_RECEIVE_CONTROL   = 8'h00;
  localparam logic [7:0] RESET_TRANSMIT_STATUS   = 8'h02;
  localparam logic [7:0] RESET_BAUD_RATE_DIVISOR = 8'h00;
  localparam logic [7:0] RESET_RECEIVE_BUFFER    = 8'h00;
  localparam logic [7:0] PERIPHERAL_IMPL_MASK    = 8'hF7;
  localparam logic [7:0] RECEIVE_WRITE_MASK      = 8'hF8;
  localparam logic [7:0] TRANSMIT_WRITE_MASK     = 8'hF5;
  localparam int WORD_W      = 9;
  localparam int COUNT_W     = 4;
  localparam logic [COUNT_W-1:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [COUNT_W-1:0] LAST_BIT_NINE  = 4'h8;
  localparam int LINK_LINES    = 2;
  localparam int LINK_CLOCK_IX = 0;
  localparam int LINK_DATA_IX  = 1;
  localparam logic [12:0] VECTOR_ADDRESS = 13'h0004;
  localparam logic [12:0] NO_VECTOR      = 13'h0000;
endpackage

// [verilog/rx_link_if.sv]
// Carries link samples to the shifter and finished words to the core.
// Assumes every signal lives on the pclk domain.
`timescale 1ns/1ps
interface rx_link_if;
  logic       sample_strobe;
  logic       sample_bit;
  logic       word_done;
  logic [8:0] word;
  modport sync_side  (output sample_strobe, output sample_bit);
  modport shift_side (input sample_strobe, input sample_bit,
                      output word_done, output word);
  modport core_side  (input word_done, input word);
endinterface

// [verilog/link_sync.sv]
// Three-stage synchroniser and glitch filter for the link clock and data.
// Assumes both pins are asynchronous to pclk.
`timescale 1ns/1ps
module link_sync
  import usart_rx_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       link_clock,
  input  wire logic       link_data,
  rx_link_if.sync_side    link
);
  logic [LINK_LINES-1:0] pins;
  logic [LINK_LINES-1:0] stage1;
  logic [LINK_LINES-1:0] stage2;
  logic [LINK_LINES-1:0] stage3;
  logic [LINK_LINES-1:0] level;
  assign pins = {link_data, link_clock};
  genvar i;
  generate
    for (i = 0; i < LINK_LINES; i++)
    begin : g_line
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          level[i]  <= 1'b0;
        end
        else
        begin
          stage1[i] <= pins[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i])
            level[i] <= stage3[i];
        end
      end
    end
  endgenerate
  // Data is taken on the falling edge of the shift clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.sample_strobe <= 1'b0;
      link.sample_bit    <= 1'b0;
    end
    else
    begin
      link.sample_strobe <= level[LINK_CLOCK_IX] && !stage3[LINK_CLOCK_IX]
                            && (stage2[LINK_CLOCK_IX] == stage3[LINK_CLOCK_IX]);
      link.sample_bit    <= level[LINK_DATA_IX];
    end
  end
endmodule

// [verilog/word_shifter.sv]
// Receive shift register: assembles eight- or nine-bit words, LSB first.
// Assumes one sample strobe per bit from the link synchroniser.
`timescale 1ns/1ps
module word_shifter
  import usart_rx_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       nine_bit,
  rx_link_if.shift_side   link
);
  logic [WORD_W-1:0]  receive_shift_register;
  logic [COUNT_W-1:0] bit_count;
  logic [COUNT_W-1:0] last_bit;
  logic [WORD_W-1:0]  next_shift;
  assign last_bit   = nine_bit ? LAST_BIT_NINE : LAST_BIT_EIGHT;
  assign next_shift = {link.sample_bit, receive_shift_register[WORD_W-1:1]};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_shift_register <= '0;
      bit_count              <= '0;
      link.word_done         <= 1'b0;
      link.word              <= '0;
    end
    else if (!enable)
    begin
      bit_count      <= '0;
      link.word_done <= 1'b0;
    end
    else
    begin
      link.word_done <= 1'b0;
      if (link.sample_strobe)
      begin
        receive_shift_register <= next_shift;
        bit_count              <= bit_count + 4'h1;
        if (bit_count == last_bit)
        begin
          bit_count      <= '0;
          link.word_done <= 1'b1;
          link.word      <= nine_bit ? next_shift : {1'b0, next_shift[8:1]};
        end
      end
    end
  end
endmodule

// [verilog/usart_sync_slave_receiver.sv]
// Synchronous slave receive path with its APB register file.
// Assumes an APB master on pclk and an external master driving the
// shift clock and data pins; the core reports sleep on core_sleep.
`timescale 1ns/1ps
module usart_sync_slave_receiver
  import usart_rx_pkg::*;
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic [usart_rx_pkg::ADDR_W-1:0] paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [usart_rx_pkg::DATA_W-1:0] pwdata,
  output logic      [usart_rx_pkg::DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           link_clock,
  input  wire logic                           link_data,
  input  wire logic                           core_sleep,
  output logic                                irq,
  output logic                                wake_request,
  output logic                                core_interrupt,
  output logic      [12:0]                    vector_address
);
  import usart_rx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [REG_W-1:0] interrupt_control;
  logic [REG_W-1:0] peripheral_enables_one;
  logic [REG_W-1:0] receive_control;
  logic [REG_W-1:0] transmit_status_control;
  logic [REG_W-1:0] baud_rate_divisor;
  logic [REG_W-1:0] receive_buffer;
  logic             receive_complete_flag;
  logic             overrun_error;
  logic             received_ninth_bit;

  logic             serial_port_enable;
  logic             nine_bit_receive_select;
  logic             continuous_receive_enable;
  logic             clock_source_select;
  logic             sync_mode;
  logic             receive_interrupt_enable;
  logic             global_interrupt_enable;
  logic             peripheral_interrupt_enable;
  logic             framing_error;

  logic             receive_active;
  logic             flag_clear;
  logic             buffer_free;
  logic             word_accept;
  logic             word_overrun;
  logic             enable_drop;
  logic             pending;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic [ADDR_W-1:0] addr_interrupt_control;
  logic [ADDR_W-1:0] addr_peripheral_flags;
  logic [ADDR_W-1:0] addr_receive_status;
  logic [ADDR_W-1:0] addr_receive_buffer;
  logic [ADDR_W-1:0] addr_peripheral_enables;
  logic [ADDR_W-1:0] addr_transmit_status;
  logic [ADDR_W-1:0] addr_baud_rate_divisor;

  assign addr_interrupt_control  = {ADDR_PAD, IDX_INTERRUPT_CONTROL, ADDR_PAD};
  assign addr_peripheral_flags   = {ADDR_PAD, IDX_PERIPHERAL_FLAGS, ADDR_PAD};
  assign addr_receive_status     = {ADDR_PAD, IDX_RECEIVE_STATUS, ADDR_PAD};
  assign addr_receive_buffer     = {ADDR_PAD, IDX_RECEIVE_BUFFER, ADDR_PAD};
  assign addr_peripheral_enables = {ADDR_PAD, IDX_PERIPHERAL_ENABLES, ADDR_PAD};
  assign addr_transmit_status    = {ADDR_PAD, IDX_TRANSMIT_STATUS, ADDR_PAD};
  assign addr_baud_rate_divisor  = {ADDR_PAD, IDX_BAUD_RATE_DIVISOR, ADDR_PAD};

  logic             setup_phase;
  logic             write_access;
  logic             hit;
  logic [REG_W-1:0] read_value;
  logic [REG_W-1:0] flags_view;
  logic [REG_W-1:0] status_view;
  logic [REG_W-1:0] wdata;

  assign setup_phase  = psel && !penable && !pready;
  assign write_access = psel && penable && pready && pwrite;
  assign wdata        = pwdata[REG_W-1:0];

  always_comb
  begin
    flags_view                       = '0;
    flags_view[RECEIVE_COMPLETE_BIT] = receive_complete_flag;
  end

  always_comb
  begin
    status_view                    = receive_control & RECEIVE_WRITE_MASK;
    status_view[FRAMING_ERROR_BIT] = framing_error;
    status_view[OVERRUN_ERROR_BIT] = overrun_error;
    status_view[NINTH_BIT_POS]     = received_ninth_bit;
  end

  always_comb
  begin
    hit        = 1'b1;
    read_value = '0;
    if (paddr == addr_interrupt_control)
      read_value = interrupt_control;
    else if (paddr == addr_peripheral_flags)
      read_value = flags_view;
    else if (paddr == addr_receive_status)
      read_value = status_view;
    else if (paddr == addr_receive_buffer)
      read_value = receive_buffer;
    else if (paddr == addr_peripheral_enables)
      read_value = peripheral_enables_one & PERIPHERAL_IMPL_MASK;
    else if (paddr == addr_transmit_status)
      read_value = transmit_status_control;
    else if (paddr == addr_baud_rate_divisor)
      read_value = baud_rate_divisor;
    else
      hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response: one access cycle, no wait states.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !hit;
      if (setup_phase && !pwrite)
        prdata <= {{(DATA_W-REG_W){1'b0}}, read_value};
      else if (!setup_phase)
        prdata <= '0;
    end
  end

  logic wr_interrupt_control;
  logic wr_peripheral_flags;
  logic wr_receive_status;
  logic wr_peripheral_enables;
  logic wr_transmit_status;
  logic wr_baud_rate_divisor;

  assign wr_interrupt_control  = write_access
                                 && (paddr == addr_interrupt_control);
  assign wr_peripheral_flags   = write_access
                                 && (paddr == addr_peripheral_flags);
  assign wr_receive_status     = write_access
                                 && (paddr == addr_receive_status);
  assign wr_peripheral_enables = write_access
                                 && (paddr == addr_peripheral_enables);
  assign wr_transmit_status    = write_access
                                 && (paddr == addr_transmit_status);
  assign wr_baud_rate_divisor  = write_access
                                 && (paddr == addr_baud_rate_divisor);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_control <= RESET_INTERRUPT_CONTROL;
    else if (wr_interrupt_control)
      interrupt_control <= wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      peripheral_enables_one <= RESET_PERIPHERAL_ENABLES;
    else if (wr_peripheral_enables)
      peripheral_enables_one <= wdata & PERIPHERAL_IMPL_MASK;
  end

  // Error and ninth-bit positions are owned by the receiver, not software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      receive_control <= RESET_RECEIVE_CONTROL;
    else if (wr_receive_status)
      receive_control <= wdata & RECEIVE_WRITE_MASK;
  end

  // No transmitter sits behind this register, so the shift register
  // always reads empty.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      transmit_status_control <= RESET_TRANSMIT_STATUS;
    else if (wr_transmit_status)
      transmit_status_control <= (wdata & TRANSMIT_WRITE_MASK)
                                 | RESET_TRANSMIT_STATUS;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_rate_divisor <= RESET_BAUD_RATE_DIVISOR;
    else if (wr_baud_rate_divisor)
      baud_rate_divisor <= wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field views.

  assign serial_port_enable          = receive_control[SERIAL_PORT_ENABLE_BIT];
  assign nine_bit_receive_select     = receive_control[NINE_BIT_SELECT_BIT];
  assign continuous_receive_enable   = receive_control[CONTINUOUS_RECEIVE_BIT];
  assign clock_source_select = transmit_status_control[CLOCK_SOURCE_BIT];
  assign sync_mode           = transmit_status_control[SYNC_MODE_BIT];
  assign receive_interrupt_enable =
    peripheral_enables_one[RECEIVE_COMPLETE_BIT];
  assign global_interrupt_enable     = interrupt_control[GLOBAL_ENABLE_BIT];
  assign peripheral_interrupt_enable =
    interrupt_control[PERIPHERAL_ENABLE_BIT];
  // A synchronous link carries no stop bit, so no framing fault can occur.
  assign framing_error = 1'b0;

  // Slave mode ignores the single-receive request and the core sleep state.
  assign receive_active = serial_port_enable && sync_mode
                          && !clock_source_select
                          && continuous_receive_enable
                          && !overrun_error;

  ////////////////////////////////////////////////////////////////////////////
  // Link front end and shift register.

  rx_link_if link ();

  link_sync u_link_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .link_clock (link_clock),
    .link_data  (link_data),
    .link       (link.sync_side)
  );

  word_shifter u_word_shifter (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (receive_active),
    .nine_bit (nine_bit_receive_select),
    .link     (link.shift_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Word completion, buffer and flags.

  assign flag_clear   = wr_peripheral_flags && wdata[RECEIVE_COMPLETE_BIT];
  assign buffer_free  = !receive_complete_flag || flag_clear;
  assign word_accept  = link.word_done && buffer_free;
  assign word_overrun = link.word_done && !buffer_free;
  assign enable_drop  = wr_receive_status && !wdata[CONTINUOUS_RECEIVE_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_buffer     <= RESET_RECEIVE_BUFFER;
      received_ninth_bit <= 1'b0;
    end
    else if (word_accept)
    begin
      receive_buffer     <= link.word[REG_W-1:0];
      received_ninth_bit <= nine_bit_receive_select
                            && link.word[REG_W];
    end
  end

  // A new word wins over a clear that lands in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      receive_complete_flag <= 1'b0;
    else if (word_accept)
      receive_complete_flag <= 1'b1;
    else if (flag_clear)
      receive_complete_flag <= 1'b0;
  end

  // Overrun stalls the receiver until continuous receive is cleared.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_error <= 1'b0;
    else if (word_overrun)
      overrun_error <= 1'b1;
    else if (enable_drop)
      overrun_error <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, wake and vector outputs.

  assign pending = receive_complete_flag && receive_interrupt_enable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= pending;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_request <= 1'b0;
    else
      wake_request <= pending && core_sleep;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_interrupt <= 1'b0;
    else
      core_interrupt <= pending && global_interrupt_enable
                        && peripheral_interrupt_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_address <= NO_VECTOR;
    else if (pending && global_interrupt_enable
             && peripheral_interrupt_enable)
      vector_address <= VECTOR_ADDRESS;
    else
      vector_address <= NO_VECTOR;
  end

endmodule

// [test/usart_rx_checker.sv]
// Concurrent checks on the receiver's port behaviour.
// Assumes it is bound into the receiver top module on pclk.
`timescale 1ns/1ps
module usart_rx_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        core_sleep,
  input wire logic        irq,
  input wire logic        wake_request,
  input wire logic        core_interrupt,
  input wire logic [12:0] vector_address
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("No ready after a setup cycle.");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("Ready held longer than one cycle.");
  property p_err_read;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("Refused access returned data.");
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Upper read data not zero.");
  property p_sticky;
    irq && !$past(psel && penable && pwrite) |=> irq;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Interrupt dropped without a write.");
  property p_wake;
    wake_request |-> irq && $past(core_sleep);
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake without interrupt in sleep.");
  property p_gate;
    core_interrupt |-> irq;
  endproperty
  a_gate: assert property (p_gate)
    else $error("Core interrupt without receive interrupt.");
  property p_vector;
    vector_address == (core_interrupt ? 13'h0004 : 13'h0000);
  endproperty
  a_vector: assert property (p_vector)
    else $error("Vector address wrong.");
  c_irq: cover property ($rose(irq));
  c_wake: cover property (wake_request);
  c_core: cover property (core_interrupt);
  c_err: cover property (pslverr);
endmodule

// [test/link_master.sv]
// Model of the external synchronous master driving clock and data.
// Assumes the receiver samples data on falling clock edges.
`timescale 1ns/1ps
module link_master
(
  output logic link_clock,
  output logic link_data
);
  initial
  begin
    link_clock = 1'b1;
    link_data  = 1'b0;
  end
  // The clock stands high between words; released data shows the inverse.
  task automatic send(input logic [8:0] w, input int n);
    #7;
    for (int i = 0; i < n; i++)
    begin
      link_data = w[i];
      #80 link_clock = 1'b0;
      #80 link_clock = 1'b1;
    end
    link_data = ~w[n-1];
  endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the synchronous slave receiver.
// Assumes the link master model and the bound checker beside the design.
`timescale 1ns/1ps
module testbench;
  import usart_rx_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        core_sleep = 1'b0;
  logic [31:0] prdata;
  logic [12:0] vector_address;
  logic        pready, pslverr, link_clock, link_data;
  logic        irq, wake_request, core_interrupt, perr;
  logic [31:0] rd;
  logic [8:0]  d;
  logic [7:0]  e_buf;
  logic        e_flag = 1'b0;
  logic        e_nin;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  ixs [7] = '{IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_FLAGS,
    IDX_RECEIVE_STATUS, IDX_RECEIVE_BUFFER, IDX_PERIPHERAL_ENABLES,
    IDX_TRANSMIT_STATUS, IDX_BAUD_RATE_DIVISOR};
  logic [7:0]  rvs [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  usart_sync_slave_receiver usart_sync_slave_receiver_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clock(link_clock), .link_data(link_data),
    .core_sleep(core_sleep), .irq(irq), .wake_request(wake_request),
    .core_interrupt(core_interrupt), .vector_address(vector_address));
  link_master link_master_i (.link_clock(link_clock),
    .link_data(link_data));
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd   = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] v);
    apb(1'b1, {2'h0, ix, ADDR_PAD}, {24'h0, v});
  endtask
  task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
    apb(1'b0, {2'h0, ix, ADDR_PAD}, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  // Sends one random word; the model takes it only while reception runs.
  task automatic rx(input int n, input bit on);
    d = 9'($urandom());
    link_master_i.send(d, n);
    repeat (12) @(posedge pclk);
    if (on && !e_flag)
    begin
      e_buf  = d[7:0];
      e_nin  = d[8];
      e_flag = 1'b1;
    end
  endtask
  task automatic clr();
    wr(IDX_PERIPHERAL_FLAGS, 8'h20);
    e_flag = 1'b0;
  endtask
  initial
  begin
    void'($urandom(32'hAE48FF92));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdc(ixs[i], rvs[i]);
    wr(IDX_PERIPHERAL_ENABLES, 8'hFF);
    rdc(IDX_PERIPHERAL_ENABLES, 8'hF7);
    wr(IDX_TRANSMIT_STATUS, 8'hFF);
    rdc(IDX_TRANSMIT_STATUS, 8'hF7);
    wr(IDX_RECEIVE_BUFFER, 8'h5A);
    rdc(IDX_RECEIVE_BUFFER, 8'h00);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'(perr), 32'h1);
    $display("Test registers finished");
    wr(IDX_TRANSMIT_STATUS, 8'h10);
    wr(IDX_PERIPHERAL_ENABLES, 8'h20);
    wr(IDX_RECEIVE_STATUS, 8'h90);
    rx(8, 1'b1);
    chk(32'(irq), 32'h1);
    rdc(IDX_PERIPHERAL_FLAGS, 8'h20);
    rdc(IDX_RECEIVE_BUFFER, e_buf);
    clr();
    wr(IDX_PERIPHERAL_ENABLES, 8'h00);
    rx(8, 1'b1);
    chk(32'(irq), 32'h0);
    rdc(IDX_PERIPHERAL_FLAGS, 8'h20);
    rdc(IDX_RECEIVE_BUFFER, e_buf);
    clr();
    wr(IDX_PERIPHERAL_ENABLES, 8'h20);
    $display("Test eight bit finished");
    wr(IDX_RECEIVE_STATUS, 8'hA0);
    rx(8, 1'b0);
    rdc(IDX_PERIPHERAL_FLAGS, 8'h00);
    $display("Test disabled finished");
    wr(IDX_RECEIVE_STATUS, 8'hD0);
    rx(9, 1'b1);
    rdc(IDX_RECEIVE_STATUS, 8'hD0 | 8'(e_nin));
    rdc(IDX_RECEIVE_BUFFER, e_buf);
    rx(9, 1'b1);
    rdc(IDX_RECEIVE_STATUS, 8'hD2 | 8'(e_nin));
    rdc(IDX_RECEIVE_BUFFER, e_buf);
    wr(IDX_RECEIVE_STATUS, 8'hC0);
    rdc(IDX_RECEIVE_STATUS, 8'hC0 | 8'(e_nin));
    clr();
    $display("Test nine bit and overrun finished");
    wr(IDX_RECEIVE_STATUS, 8'h90);
    wr(IDX_INTERRUPT_CONTROL, 8'hC0);
    core_sleep <= 1'b1;
    rx(8, 1'b1);
    chk(32'(wake_request), 32'h1);
    chk(32'(core_interrupt), 32'h1);
    chk(32'(vector_address), 32'h4);
    rdc(IDX_RECEIVE_BUFFER, e_buf);
    wr(IDX_INTERRUPT_CONTROL, 8'h80);
    repeat (2) @(posedge pclk);
    chk(32'(core_interrupt), 32'h0);
    chk(32'(vector_address), 32'h0);
    core_sleep <= 1'b0;
    clr();
    repeat (2) @(posedge pclk);
    chk(32'(wake_request), 32'h0);
    $display("Test sleep finished");
    results();
  end
endmodule
bind usart_sync_slave_receiver usart_rx_checker usart_rx_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_sleep(core_sleep), .irq(irq), .wake_request(wake_request),
  .core_interrupt(core_interrupt), .vector_address(vector_address));
